// file: rtl/rtc_consts.vh
// Constants for the reloadable capture timer: mode codes, interrupt
// source codes and reset values.
// Assumes inclusion by bare name from every timer design file.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// Timer mode codes
`define RTC_MODE_CONTINUOUS 2'h0
`define RTC_MODE_COUNTER 2'h1
`define RTC_MODE_CAPCMP 2'h2
`define RTC_MODE_DUAL_PWM 2'h3

// Interrupt source select codes
`define RTC_ISEL_BOTH 2'h0
`define RTC_ISEL_BOTH_ALT 2'h1
`define RTC_ISEL_CAPTURE 2'h2
`define RTC_ISEL_RELOAD 2'h3

// Reset and start values
`define RTC_COUNT_START 16'h0001
`define RTC_COUNT_RESET 16'h0001
`define RTC_BYTE_RESET 8'h00
`define RTC_PRESCALE_RESET 7'h00

`endif

// file: rtl/rtc_prescaler.v
// Prescaler for the reloadable capture timer: one-cycle tick every
// 2**prescaleSel system clocks while running.
// Assumes run and prescaleSel come from logic on the same clock.
`timescale 1ns/1ps
`include "rtc_consts.vh"

module rtc_prescaler #(
  parameter SEL_WIDTH = 3,
  parameter DIV_WIDTH = 7
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire run,
  input wire [SEL_WIDTH-1:0] prescaleSel,
  // Tick
  output reg tick
);

  reg [DIV_WIDTH-1:0] div_reg;
  reg [DIV_WIDTH-1:0] div_next;
  reg tick_next;
  reg [DIV_WIDTH-1:0] mask;
  integer i;

  always @* begin
    mask = {DIV_WIDTH{1'b0}};
    for (i = 0; i < DIV_WIDTH; i = i + 1) begin
      if (i < prescaleSel) begin
        mask[i] = 1'b1;
      end
    end
    div_next = div_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    tick_next = 1'b0;
    if (!run) begin
      div_next = `RTC_PRESCALE_RESET;
    end else if ((div_reg & mask) == mask) begin
      div_next = `RTC_PRESCALE_RESET;
      tick_next = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= `RTC_PRESCALE_RESET;
      tick <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick <= tick_next;
    end
  end

endmodule

// file: rtl/rtc_timer.v
// Reloadable 16-bit timer with capture/compare start, coherent count
// read and shared timer input / complementary output pin.
// Assumes control inputs and read strobes come from logic on clk; the
// timer pin input is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "rtc_consts.vh"

// Contract
// - In capture/compare mode the counter waits after enable and starts on the first input edge.
// - The input edge that starts counting in capture/compare mode raises no interrupt.
// - By default the interrupt fires on both capture events and reload events.
// - An interrupt source select field restricts the interrupt to capture only or reload only.
// - Reading the count never disturbs counting, reloads or interrupts.
// - A high byte read while enabled copies the live low byte into a holding latch.
// - The low byte read after such a high byte read returns the latched value.
// - While disabled a low byte read returns the live low byte directly.
// - The timer output inverts on every reload of the counter.
// - The timer input can be a counting source and shares the complementary output pin.
// - With the pin routed to the timer, it is an input in every mode except dual PWM.
module rtc_timer #(
  parameter COUNT_WIDTH = 16,
  parameter SEL_WIDTH = 3,
  parameter DIV_WIDTH = 7
) (
  // Clock and reset
  clk,
  rst_b,
  // Timer control zero and companions
  timerEnable,
  timerMode,
  interruptSourceSelect,
  inputFalling,
  prescaleSel,
  reloadValue,
  pinAltFunc,
  // Count read
  readHighStrobe,
  readLowStrobe,
  readData,
  // Capture result and event
  captureValue,
  timerIrq,
  // Timer output and shared pin
  timerOut,
  pinIn,
  pinOut,
  pinOutEn
);

  input wire clk;
  input wire rst_b;
  input wire timerEnable;
  input wire [1:0] timerMode;
  input wire [1:0] interruptSourceSelect;
  input wire inputFalling;
  input wire [SEL_WIDTH-1:0] prescaleSel;
  input wire [COUNT_WIDTH-1:0] reloadValue;
  input wire pinAltFunc;
  input wire readHighStrobe;
  input wire readLowStrobe;
  output reg [7:0] readData;
  output reg [COUNT_WIDTH-1:0] captureValue;
  output reg timerIrq;
  output reg timerOut;
  input wire pinIn;
  output reg pinOut;
  output reg pinOutEn;

  // ***************************************
  // Pin synchroniser and edge detection
  // ***************************************
  reg pinSync1_reg;
  reg pinSync2_reg;
  reg pinPrev_reg;
  wire pinIsInput;
  wire inEdge;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
      pinPrev_reg <= 1'b0;
    end else begin
      pinSync1_reg <= pinIn;
      pinSync2_reg <= pinSync1_reg;
      pinPrev_reg <= pinSync2_reg;
    end
  end

  assign pinIsInput = pinAltFunc && (timerMode != `RTC_MODE_DUAL_PWM);
  assign inEdge = pinIsInput && timerEnable &&
    (inputFalling ? (pinPrev_reg && !pinSync2_reg) : (!pinPrev_reg && pinSync2_reg));

  // ***************************************
  // Prescaler
  // ***************************************
  wire tick;

  rtc_prescaler #(
    .SEL_WIDTH(SEL_WIDTH),
    .DIV_WIDTH(DIV_WIDTH)
  ) prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .run(timerEnable),
    .prescaleSel(prescaleSel),
    .tick(tick)
  );

  // ***************************************
  // Counter, capture and interrupt
  // ***************************************
  reg [COUNT_WIDTH-1:0] count_reg;
  reg [COUNT_WIDTH-1:0] count_next;
  reg started_reg;
  reg started_next;
  reg [COUNT_WIDTH-1:0] capture_next;
  reg irq_next;
  reg toggle;
  reg capEvent;
  reg advance;

  function irqAllowed;
    input [1:0] isel;
    input isCapture;
    begin
      case (isel)
        `RTC_ISEL_CAPTURE: irqAllowed = isCapture;
        `RTC_ISEL_RELOAD: irqAllowed = !isCapture;
        default: irqAllowed = 1'b1;
      endcase
    end
  endfunction

  always @* begin
    count_next = count_reg;
    started_next = started_reg;
    capture_next = captureValue;
    irq_next = 1'b0;
    toggle = 1'b0;
    capEvent = 1'b0;
    advance = 1'b0;
    if (!timerEnable) begin
      started_next = 1'b0;
    end else begin
      case (timerMode)
        `RTC_MODE_COUNTER: begin
          advance = inEdge;
        end
        `RTC_MODE_CAPCMP: begin
          if (!started_reg) begin
            started_next = inEdge;
          end else begin
            advance = tick;
            capEvent = inEdge;
          end
        end
        default: begin
          advance = tick;
        end
      endcase
      if (capEvent) begin
        capture_next = count_reg;
        count_next = `RTC_COUNT_START;
        irq_next = irqAllowed(interruptSourceSelect, 1'b1);
      end else if (advance) begin
        if (count_reg == reloadValue) begin
          count_next = `RTC_COUNT_START;
          toggle = 1'b1;
          irq_next = irqAllowed(interruptSourceSelect, 1'b0);
        end else begin
          count_next = count_reg + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= `RTC_COUNT_RESET;
      started_reg <= 1'b0;
      captureValue <= {COUNT_WIDTH{1'b0}};
      timerIrq <= 1'b0;
      timerOut <= 1'b0;
      pinOut <= 1'b1;
      pinOutEn <= 1'b0;
    end else begin
      count_reg <= count_next;
      started_reg <= started_next;
      captureValue <= capture_next;
      timerIrq <= irq_next;
      if (toggle) begin
        timerOut <= !timerOut;
        pinOut <= timerOut;
      end
      pinOutEn <= pinAltFunc && (timerMode == `RTC_MODE_DUAL_PWM);
    end
  end

  // ***************************************
  // Coherent count read
  // ***************************************
  reg [7:0] holdLow_reg;
  reg holdValid_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readData <= `RTC_BYTE_RESET;
      holdLow_reg <= `RTC_BYTE_RESET;
      holdValid_reg <= 1'b0;
    end else begin
      if (readHighStrobe) begin
        readData <= count_reg[15:8];
        if (timerEnable) begin
          holdLow_reg <= count_reg[7:0];
          holdValid_reg <= 1'b1;
        end
      end else if (readLowStrobe) begin
        if (timerEnable && holdValid_reg) begin
          readData <= holdLow_reg;
        end else begin
          readData <= count_reg[7:0];
        end
        holdValid_reg <= 1'b0;
      end
      if (!timerEnable) begin
        holdValid_reg <= 1'b0;
      end
    end
  end

endmodule

// file: tb/rtc_pin_src.sv
// Pin source model: one input pulse per request.
// Assumes fire is a one-cycle request on clk.
`timescale 1ns/1ps
module rtc_pin_src (
  // Clock
  input wire clk,
  // Request and pin level
  input wire fire,
  output wire level
);
  reg level_reg = 1'b0;
  reg [2:0] hold_reg = 3'h0;
  assign level = level_reg;
  // High four cycles, so each level lasts two or more
  always @(posedge clk) begin
    if (fire) begin
      level_reg <= 1'b1;
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
      level_reg <= (hold_reg != 3'h1);
    end
  end
endmodule

// file: tb/rtc_timer_chk.sv
// Checker: properties on the timer top ports.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module rtc_timer_chk #(
  parameter COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Control
  input wire timerEnable,
  input wire [1:0] timerMode,
  input wire [1:0] interruptSourceSelect,
  input wire pinAltFunc,
  input wire readHighStrobe,
  input wire readLowStrobe,
  // Results
  input wire [7:0] readData,
  input wire [COUNT_WIDTH-1:0] captureValue,
  input wire timerIrq,
  input wire timerOut,
  input wire pinOut,
  input wire pinOutEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pin_complement: assert property (pinOut == !timerOut)
    else $error("pin not complement");
  a_reload_irq: assert property (
    $changed(timerOut) && $past(interruptSourceSelect) != 2'h2 |-> timerIrq)
    else $error("reload irq missing");
  a_capture_only: assert property (
    $past(interruptSourceSelect) == 2'h2 && $changed(timerOut) |-> !timerIrq)
    else $error("reload irq masked");
  a_reload_only: assert property (
    $past(interruptSourceSelect) == 2'h3 && timerIrq |-> $changed(timerOut))
    else $error("capture irq masked");
  a_capture_irq: assert property (
    $changed(captureValue) && $past(interruptSourceSelect) != 2'h3 |-> timerIrq)
    else $error("capture irq missing");
  a_capture_mode: assert property (
    $changed(captureValue) |-> $past(timerMode) == 2'h2 && $past(timerEnable))
    else $error("capture outside mode");
  a_idle_quiet: assert property (
    !timerEnable ##1 !timerEnable |-> !timerIrq && $stable(timerOut))
    else $error("idle activity");
  a_read_hold: assert property (
    !readHighStrobe && !readLowStrobe |=> $stable(readData))
    else $error("read data moved");
  a_pin_input: assert property (
    pinAltFunc && timerMode != 2'h3 |=> !pinOutEn)
    else $error("pin driven as input");
  a_pwm_drive: assert property (
    pinAltFunc && timerMode == 2'h3 |=> pinOutEn)
    else $error("pin not driven in pwm");
endmodule

// file: tb/test_rtc_timer.sv
// Bench: reload rows, capture start, coherent reads.
// Assumes rtc_timer, the checker and the pin source model.
`timescale 1ns/1ps
module test_rtc_timer;
  reg clk = 0;
  reg rst_b = 0;
  reg en = 0;
  reg [1:0] mode = 0;
  reg [1:0] isel = 0;
  reg [2:0] sel = 0;
  reg [15:0] rld = 16'h0002;
  reg alt = 0;
  reg rdHi = 0;
  reg rdLo = 0;
  reg fire = 0;
  reg fall = 0;
  reg [7:0] lo0;
  wire [7:0] rdData;
  wire [15:0] capVal;
  wire irq, tOut, pOut, pOutEn, srcLevel;
  wire pinWire = pOutEn ? pOut : srcLevel;
  integer miscompares = 0;
  integer total_checks = 0;
  integer i, n;
  // Rows: sel, isel, reload, toggle period, irq expected
  reg [37:0] rows [0:3];
  always #4 clk = ~clk;
  rtc_timer DUT (.clk(clk), .rst_b(rst_b), .timerEnable(en), .timerMode(mode),
    .interruptSourceSelect(isel), .inputFalling(fall), .prescaleSel(sel),
    .reloadValue(rld), .pinAltFunc(alt), .readHighStrobe(rdHi), .readLowStrobe(rdLo),
    .readData(rdData), .captureValue(capVal), .timerIrq(irq), .timerOut(tOut),
    .pinIn(pinWire), .pinOut(pOut), .pinOutEn(pOutEn));
  rtc_pin_src src (.clk(clk), .fire(fire), .level(srcLevel));
  task tick(input integer k);
    begin repeat (k) @(posedge clk); #1; end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task waitEdge(output integer c);
    reg last;
    begin
      last = tOut;
      c = 0;
      while (tOut === last && c < 300) begin tick(1); c = c + 1; end
      if (c >= 300) begin miscompares = miscompares + 1; wrap_up; end
    end
  endtask
  task doReset;
    begin rst_b = 0; en = 0; tick(8); rst_b = 1; tick(1); end
  endtask
  initial begin
    rows[0] = {3'h0, 2'h0, 16'h0002, 16'h0002, 1'h1};
    rows[1] = {3'h1, 2'h1, 16'h0003, 16'h0006, 1'h1};
    rows[2] = {3'h2, 2'h2, 16'h0005, 16'h0014, 1'h0};
    rows[3] = {3'h0, 2'h3, 16'h0001, 16'h0001, 1'h1};
    for (i = 0; i < 4; i = i + 1) begin
      doReset;
      {sel, isel, rld} = rows[i][37:17];
      en = 1;
      waitEdge(n);
      waitEdge(n);
      cmp(n[15:0], rows[i][16:1]);
      cmp({15'h0000, irq}, {15'h0000, rows[i][0]});
      $display("reload row %0d done", i);
    end
    doReset;
    {sel, isel, mode, rld} = {3'h0, 2'h0, 2'h2, 16'hFFFF};
    alt = 1;
    tick(1);
    en = 1;
    for (i = 0; i < 3; i = i + 1) begin
      fire = 1; tick(1); fire = 0; n = 0;
      repeat (39) begin tick(1); n = n + irq; end
      cmp(n[15:0], (i > 0) ? 16'h0001 : 16'h0000);
      if (i > 0) cmp(capVal, 16'h0028);
    end
    cmp(capVal, 16'h0028);
    $display("capture test done");
    doReset;
    {alt, mode, rld} = {1'h0, 2'h0, 16'hFFFF};
    en = 1;
    tick(5);
    rdLo = 1; tick(1); rdLo = 0; lo0 = rdData;
    rdHi = 1; tick(1); rdHi = 0; tick(4);
    rdLo = 1; tick(1);
    cmp(rdData, {8'h00, lo0 + 8'h01});
    tick(1); rdLo = 0;
    cmp(rdData, {8'h00, lo0 + 8'h07});
    rdHi = 1; tick(1); rdHi = 0; tick(2);
    en = 0; tick(2);
    rdLo = 1; tick(1); rdLo = 0;
    cmp(rdData, {8'h00, lo0 + 8'h0B});
    tick(1);
    rdLo = 1; tick(1); rdLo = 0; lo0 = rdData; tick(3);
    rdHi = 1; tick(1); rdHi = 0; rdLo = 1; tick(1); rdLo = 0;
    cmp(rdData, {8'h00, lo0});
    $display("read test done");
    doReset;
    {alt, fall, mode, rld} = {1'h1, 1'h1, 2'h1, 16'hFFFF};
    en = 1;
    for (i = 0; i < 3; i = i + 1) begin
      fire = 1; tick(1); fire = 0; tick(9);
    end
    rdLo = 1; tick(1); rdLo = 0; mode = 2'h3;
    cmp({8'h00, rdData}, 16'h0004);
    tick(2);
    cmp({15'h0000, pOutEn}, 16'h0001);
    $display("pin test done");
    wrap_up;
  end
endmodule
bind rtc_timer rtc_timer_chk #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.clk(clk), .rst_b(rst_b),
  .timerEnable(timerEnable), .timerMode(timerMode), .pinAltFunc(pinAltFunc),
  .interruptSourceSelect(interruptSourceSelect), .readHighStrobe(readHighStrobe),
  .readLowStrobe(readLowStrobe), .readData(readData), .captureValue(captureValue),
  .timerIrq(timerIrq), .timerOut(timerOut), .pinOut(pinOut), .pinOutEn(pinOutEn));
